// file: lcdc_ctrl.sv
`timescale 1ns/1ps

module lcdc_ctrl import lcdc_pkg::*; #(
  parameter int unsigned P_PWRON_CYC = CYC_PWRON,
  parameter int unsigned P_INIT1_CYC = CYC_INIT1,
  parameter int unsigned P_INIT2_CYC = CYC_INIT2,
  parameter int unsigned P_CLEAR_CYC = CYC_CLEAR
) (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       ENABLE,
  input  wire logic       WR_VALID,
  output logic            WR_READY,
  input  wire logic       WR_RS,
  input  wire logic [7:0] WR_BYTE,
  output logic            READY,
  output logic [3:0]      NIBBLE_BUS,
  output logic            CMD_DATA_SELECT,
  output logic            READ_WRITE_SELECT,
  output logic            TRANSFER_STROBE
);

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------

  // Sequencer state, step index, held byte and its wait.
  lcdc_st_e         st_q, st_d;
  logic [3:0]       idx_q, idx_d;
  logic [7:0]       byte_q, byte_d;
  logic             rs_q, rs_d;
  logic             lo_q, lo_d;
  logic             addr_q, addr_d;
  logic             rdy_q, rdy_d;
  logic [CNT_W-1:0] gap_q, gap_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [3:0]       nxt_idx;

  // Request to the nibble writer and its answer.
  logic             launch;
  logic [3:0]       l_nib;
  logic             l_rs;
  logic             wr_done;

  // Head of the input buffer.
  logic             buf_valid;
  logic             buf_pop;
  logic [BUF_W-1:0] buf_data;

  // -----------------------------------------------------------------------
  // Decoding helpers
  // -----------------------------------------------------------------------

  // Wait that follows each of the four wake-up nibbles.
  // Waits count from the end of the hold cycle, so they run one cycle long.
  function automatic logic [CNT_W-1:0] init_gap(input logic [3:0] i);
    case (i)
      4'd0:    return CNT_W'(P_INIT1_CYC);
      4'd1:    return CNT_W'(P_INIT2_CYC);
      default: return CNT_W'(CYC_INIT3);
    endcase
  endfunction

  // Nibble sent at each wake-up step: three wake nibbles, then the 4-bit one.
  function automatic logic [3:0] init_nib(input logic [3:0] i);
    return (i == 4'(INIT_LAST)) ? NIB_4BIT : NIB_WAKE;
  endfunction

  // Configuration bytes in the order they go out.
  // Steps 4 to 7 are all commands, sent upper nibble first.
  function automatic logic [7:0] cfg_byte(input logic [3:0] i);
    case (i)
      4'd4:    return CMD_FUNC;
      4'd5:    return CMD_ENTRY;
      4'd6:    return CMD_DISP;
      default: return CMD_CLEAR;
    endcase
  endfunction

  // Clear and return-home run long inside the display; all else is short.
  // The display's busy flag is never read, so the worst-case time is used.
  // Return-home shares the long wait; slower, but no byte is ever lost.
  function automatic logic [CNT_W-1:0] byte_gap(input logic r,
                                                input logic [7:0] b);
    if (!r && (b[7:2] == 6'b0)) begin
      return CNT_W'(P_CLEAR_CYC);
    end
    return CNT_W'(CYC_BYTE_GAP);
  endfunction

  // -----------------------------------------------------------------------
  // Input buffer
  // -----------------------------------------------------------------------

  // Holds up to two user bytes while a transfer or a wait is running.
  // It keeps filling while the display is parked; nothing is dropped.
  lcdc_pipe2 #(
    .W (BUF_W)
  ) u_buf (
    .clk       (CLK),
    .rst       (SYS_RST),
    .in_valid  (WR_VALID),
    .in_ready  (WR_READY),
    .in_data   ({WR_RS, WR_BYTE}),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  // -----------------------------------------------------------------------
  // Nibble writer
  // -----------------------------------------------------------------------

  // The bus, select and strobe pins come from flops inside the writer.
  // Its done flag marks the hold cycle after the strobe has fallen.
  lcdc_nib_wr u_wr (
    .clk     (CLK),
    .rst     (SYS_RST),
    .start   (launch),
    .nib     (l_nib),
    .rs      (l_rs),
    .done    (wr_done),
    .nib_out (NIBBLE_BUS),
    .rs_out  (CMD_DATA_SELECT),
    .strobe  (TRANSFER_STROBE)
  );

  // -----------------------------------------------------------------------
  // Pin outputs
  // -----------------------------------------------------------------------

  // Reading back is never needed, so the display never drives the bus.
  assign READ_WRITE_SELECT = 1'b0;
  assign READY             = rdy_q;

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------

  // Steps 0-3 are the wake-up nibbles, 4-7 the configuration bytes, and
  // step 8 means the display is ready for user traffic.
  // Fixed worst-case waits replace polling, so no pin is ever read back;
  // the price is a slower stream than the display could take.
  always_comb begin
    st_d    = st_q;
    idx_d   = idx_q;
    byte_d  = byte_q;
    rs_d    = rs_q;
    lo_d    = lo_q;
    addr_d  = addr_q;
    rdy_d   = rdy_q;
    gap_d   = gap_q;
    cnt_d   = cnt_q;
    launch  = 1'b0;
    l_nib   = 4'h0;
    l_rs    = 1'b0;
    buf_pop = 1'b0;
    nxt_idx = idx_q + 4'd1;
    case (st_q)
      // While disabled the strobe stays low and the wait keeps reloading.
      ST_PWRON: begin
        if (!ENABLE) begin
          cnt_d = CNT_W'(P_PWRON_CYC);
        end else if (cnt_q == '0) begin
          launch = 1'b1;
          l_nib  = init_nib(4'd0);
          gap_d  = init_gap(4'd0);
          idx_d  = 4'd0;
          st_d   = ST_NIB;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      // Wait until the strobe has fallen and the hold time is met.
      // The wait that follows was chosen when the nibble was launched.
      ST_NIB: begin
        if (wr_done) begin
          cnt_d = gap_q;
          st_d  = ST_GAP;
        end
      end
      // Count the wait down, then pick the next nibble: the lower half of a
      // held byte, a wake-up step, or a configuration byte.
      ST_GAP: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - CNT_W'(1);
        end else if (!ENABLE && !rdy_q) begin
          // Parked before ready: the next step waits until enabled, so an
          // unused display never sees a strobe.
          st_d = ST_GAP;
        end else if (lo_q) begin
          // Lower nibble of the held byte; the select does not change.
          launch = 1'b1;
          l_nib  = byte_q[3:0];
          l_rs   = rs_q;
          gap_d  = byte_gap(rs_q, byte_q);
          lo_d   = 1'b0;
          st_d   = ST_NIB;
        end else if (idx_q < 4'(INIT_LAST)) begin
          launch = 1'b1;
          l_nib  = init_nib(nxt_idx);
          gap_d  = init_gap(nxt_idx);
          idx_d  = nxt_idx;
          st_d   = ST_NIB;
        end else if (idx_q < 4'(CFG_LAST)) begin
          // Configuration bytes are commands, upper nibble first.
          launch = 1'b1;
          byte_d = cfg_byte(nxt_idx);
          l_nib  = byte_d[7:4];
          rs_d   = 1'b0;
          l_rs   = 1'b0;
          lo_d   = 1'b1;
          gap_d  = CNT_W'(CYC_NIB_GAP);
          idx_d  = nxt_idx;
          st_d   = ST_NIB;
        end else begin
          idx_d = 4'(CFG_LAST + 1);
          rdy_d = 1'b1;
          st_d  = ST_IDLE;
        end
      end
      // Take a user byte once the previous one has fully settled.
      // Enable low here only pauses popping; a byte in flight completes.
      ST_IDLE: begin
        if (ENABLE && buf_valid) begin
          launch = 1'b1;
          rs_d   = 1'b0;
          lo_d   = 1'b1;
          gap_d  = CNT_W'(CYC_NIB_GAP);
          st_d   = ST_NIB;
          if (buf_data[8] && !addr_q) begin
            // Character data with no address yet: home the pointer first
            // and leave the data byte in the buffer for the next turn.
            byte_d = CMD_SET_ADDR;
            addr_d = 1'b1;
          end else begin
            buf_pop = 1'b1;
            byte_d  = buf_data[7:0];
            rs_d    = buf_data[8];
            if (!buf_data[8] && buf_data[7]) begin
              addr_d = 1'b1;
            end
          end
          l_nib = byte_d[7:4];
          l_rs  = rs_d;
        end
      end
      default: st_d = ST_PWRON;
    endcase
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------

  // Register stage. Line wrap is not emulated: the user sends a fresh
  // address command to reach the second line.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_q   <= ST_PWRON;
      idx_q  <= 4'd0;
      byte_q <= 8'h00;
      rs_q   <= 1'b0;
      lo_q   <= 1'b0;
      addr_q <= 1'b0;
      rdy_q  <= 1'b0;
      gap_q  <= '0;
      cnt_q  <= CNT_W'(P_PWRON_CYC);
    end else begin
      st_q   <= st_d;
      idx_q  <= idx_d;
      byte_q <= byte_d;
      rs_q   <= rs_d;
      lo_q   <= lo_d;
      addr_q <= addr_d;
      rdy_q  <= rdy_d;
      gap_q  <= gap_d;
      cnt_q  <= cnt_d;
    end
  end

endmodule // lcdc_ctrl

// file: lcdc_ctrl_monitor.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Pin checks of the display controller
// ----------------------------------------------------------------------
module lcdc_ctrl_monitor import lcdc_pkg::*; #(
  parameter int unsigned P_PWRON_CYC = CYC_PWRON,
  parameter int unsigned P_INIT1_CYC = CYC_INIT1,
  parameter int unsigned P_INIT2_CYC = CYC_INIT2,
  parameter int unsigned P_CLEAR_CYC = CYC_CLEAR
) (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       ENABLE,
  input wire logic       WR_VALID,
  input wire logic       WR_READY,
  input wire logic       WR_RS,
  input wire logic [7:0] WR_BYTE,
  input wire logic       READY,
  input wire logic [3:0] NIBBLE_BUS,
  input wire logic       CMD_DATA_SELECT,
  input wire logic       READ_WRITE_SELECT,
  input wire logic       TRANSFER_STROBE
);
  int unsigned low_q;
  int unsigned high_q;
  int unsigned nibs_q;
  int unsigned wake_gap;
  logic [3:0]  up_q;
  logic        sel_q;
  logic        long_q;

  // The first two wake-up nibbles have their own waits; later ones use the byte gap.
  assign wake_gap = (nibs_q == 1) ? P_INIT1_CYC :
                    (nibs_q == 2) ? P_INIT2_CYC : CYC_BYTE_GAP;

  // Low and high run lengths of the strobe, and what the last byte was.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      low_q  <= 0;
      high_q <= 0;
      nibs_q <= 0;
      up_q   <= 4'h0;
      sel_q  <= 1'b0;
      long_q <= 1'b0;
    end else begin
      low_q  <= TRANSFER_STROBE ? 0 : low_q + 1;
      high_q <= TRANSFER_STROBE ? high_q + 1 : 0;
      if (high_q != 0 && !TRANSFER_STROBE) begin
        nibs_q <= nibs_q + 1;
        if (!nibs_q[0]) begin
          up_q  <= NIBBLE_BUS;
          sel_q <= CMD_DATA_SELECT;
        end else begin
          long_q <= !CMD_DATA_SELECT && up_q == 4'h0 &&
                    NIBBLE_BUS[3:2] == 2'h0;
        end
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_rise;
    $rose(TRANSFER_STROBE);
  endsequence

  sequence s_fall;
    $fell(TRANSFER_STROBE);
  endsequence

  a_strobe_width: assert property (s_fall |-> high_q == CYC_STROBE)
    else $error("strobe pulse length wrong");
  a_write_only: assert property (READ_WRITE_SELECT == 1'b0)
    else $error("read/write select left write");
  a_parked_idle: assert property (
    !ENABLE && !READY && !TRANSFER_STROBE |=> !TRANSFER_STROBE)
    else $error("strobe raised while unused");
  a_hold_steady: assert property (
    s_fall |-> ($stable(NIBBLE_BUS) && $stable(CMD_DATA_SELECT))[*2])
    else $error("pins moved around strobe fall");
  a_power_wait: assert property (
    s_rise |-> nibs_q != 0 || low_q >= P_PWRON_CYC)
    else $error("first strobe too early");
  a_wake_nibble: assert property (
    s_rise |-> nibs_q >= 4 ||
      NIBBLE_BUS == (nibs_q == 3 ? NIB_4BIT : NIB_WAKE))
    else $error("wrong wake-up nibble");
  a_wake_gaps: assert property (
    s_rise |-> nibs_q == 0 || nibs_q > 4 || low_q >= wake_gap)
    else $error("wake-up wait too short");
  a_nibble_gap: assert property (
    s_rise |-> nibs_q < 5 || !nibs_q[0] ||
      (low_q >= CYC_NIB_GAP && CMD_DATA_SELECT == sel_q))
    else $error("nibble pair gap or select wrong");
  a_byte_gap: assert property (
    s_rise |-> nibs_q < 6 || nibs_q[0] ||
      low_q >= (long_q ? P_CLEAR_CYC : CYC_BYTE_GAP))
    else $error("byte gap too short");
  a_config_done: assert property (
    $rose(READY) |-> nibs_q == 12 && long_q)
    else $error("ready before configuration ended");

endmodule // lcdc_ctrl_monitor

bind lcdc_ctrl lcdc_ctrl_monitor #(
  .P_PWRON_CYC(P_PWRON_CYC),
  .P_INIT1_CYC(P_INIT1_CYC),
  .P_INIT2_CYC(P_INIT2_CYC),
  .P_CLEAR_CYC(P_CLEAR_CYC)
) u_mon (
  .CLK(CLK), .SYS_RST(SYS_RST), .ENABLE(ENABLE), .WR_VALID(WR_VALID),
  .WR_READY(WR_READY), .WR_RS(WR_RS), .WR_BYTE(WR_BYTE), .READY(READY),
  .NIBBLE_BUS(NIBBLE_BUS), .CMD_DATA_SELECT(CMD_DATA_SELECT),
  .READ_WRITE_SELECT(READ_WRITE_SELECT), .TRANSFER_STROBE(TRANSFER_STROBE)
);

// file: lcdc_disp_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Behavioural character display on the far side
// ----------------------------------------------------------------------
module lcdc_disp_model import lcdc_pkg::*; #(
  parameter int unsigned P_CLEAR_CYC = CYC_CLEAR
) (
  input  wire logic       clk,
  input  wire logic       transfer_strobe,
  input  wire logic [3:0] nibble_bus,
  input  wire logic       cmd_data_select,
  input  wire logic       read_write_select,
  output logic            ev_q,
  output logic            ev_init_q,
  output logic            ev_rs_q,
  output logic [7:0]      ev_byte_q,
  output logic            viol_q
);
  logic [7:0]  display_char_ram [128];
  logic [6:0]  addr_q = 7'h00;
  logic [3:0]  up_q = 4'h0;
  logic        st_q = 1'b0;
  int unsigned nibs_q = 0;
  int unsigned busy_q = 0;
  logic [7:0]  b;

  initial viol_q = 1'b0;
  initial ev_q = 1'b0;
  assign b = {up_q, nibble_bus};

  // The part has no reset; a busy count stands in for the busy_flag.
  always @(posedge clk) begin
    st_q <= transfer_strobe;
    ev_q <= 1'b0;
    if (busy_q != 0) busy_q <= busy_q - 1;
    // A transfer while busy would be lost on the real part.
    if (transfer_strobe && !st_q && busy_q != 0) viol_q <= 1'b1;
    // Pins count only at the falling strobe, so a low strobe ignores them.
    if (!transfer_strobe && st_q && !read_write_select) begin
      nibs_q <= nibs_q + 1;
      ev_rs_q <= cmd_data_select;
      if (nibs_q < 4) begin
        ev_q <= 1'b1;
        ev_init_q <= 1'b1;
        ev_byte_q <= {4'h0, nibble_bus};
      end else if (!nibs_q[0]) begin
        up_q <= nibble_bus;
      end else begin
        ev_q <= 1'b1;
        ev_init_q <= 1'b0;
        ev_byte_q <= b;
        busy_q <= (!cmd_data_select && b[7:2] == 6'h00) ?
                  P_CLEAR_CYC : CYC_BYTE_GAP;
        if (cmd_data_select) begin
          display_char_ram[addr_q] <= b;
          addr_q <= addr_q + 7'h01;
        end else if (b[7]) begin
          addr_q <= b[6:0];
        end else if (b == CMD_CLEAR) begin
          for (int i = 0; i < 128; i++) display_char_ram[i] <= 8'h20;
          addr_q <= 7'h00;
        end else if (b[7:1] == 7'h01) begin
          // Return home moves the pointer and keeps the characters.
          addr_q <= 7'h00;
        end
      end
    end
  end

endmodule // lcdc_disp_model

// file: lcdc_nib_wr.sv
`timescale 1ns/1ps

// Writes one nibble: setup, strobe high, hold, then reports done.
module lcdc_nib_wr import lcdc_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [3:0] nib,
  input  wire logic       rs,
  output logic            done,
  output logic [3:0]      nib_out,
  output logic            rs_out,
  output logic            strobe
);

  lcdc_wr_e          st_q, st_d;
  logic [WCNT_W-1:0] cnt_q, cnt_d;
  logic [3:0]        nib_q, nib_d;
  logic              rs_q, rs_d, stb_q, stb_d;

  // -----------------------------------------------------------------------
  // Strobe sequencing
  // -----------------------------------------------------------------------

  // Bus and select change only in idle, so they are stable around the pulse.
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    nib_d = nib_q;
    rs_d  = rs_q;
    case (st_q)
      WR_IDLE: begin
        if (start) begin
          nib_d = nib;
          rs_d  = rs;
          cnt_d = WCNT_W'(CYC_SETUP - 1);
          st_d  = WR_SETUP;
        end
      end
      WR_SETUP: begin
        if (cnt_q == '0) begin
          cnt_d = WCNT_W'(CYC_STROBE - 1);
          st_d  = WR_PULSE;
        end else begin
          cnt_d = cnt_q - WCNT_W'(1);
        end
      end
      WR_PULSE: begin
        if (cnt_q == '0) begin
          cnt_d = WCNT_W'(CYC_HOLD - 1);
          st_d  = WR_HOLD;
        end else begin
          cnt_d = cnt_q - WCNT_W'(1);
        end
      end
      WR_HOLD: begin
        if (cnt_q == '0) begin
          st_d = WR_IDLE;
        end else begin
          cnt_d = cnt_q - WCNT_W'(1);
        end
      end
      default: st_d = WR_IDLE;
    endcase
    stb_d = (st_d == WR_PULSE);
  end

  // Register stage; the strobe is a flop so it cannot glitch.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q  <= WR_IDLE;
      cnt_q <= '0;
      nib_q <= 4'h0;
      rs_q  <= 1'b0;
      stb_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      nib_q <= nib_d;
      rs_q  <= rs_d;
      stb_q <= stb_d;
    end
  end

  assign done    = (st_q == WR_HOLD) && (cnt_q == '0);
  assign nib_out = nib_q;
  assign rs_out  = rs_q;
  assign strobe  = stb_q;

endmodule // lcdc_nib_wr

// file: lcdc_pipe2.sv
`timescale 1ns/1ps

// Two-entry buffer between the user's byte stream and the sequencer.
module lcdc_pipe2 import lcdc_pkg::*; #(
  parameter int unsigned W = BUF_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  logic [W-1:0] mem_q [BUF_DEPTH];
  logic [W-1:0] mem_d [BUF_DEPTH];
  logic         wp_q, wp_d, rp_q, rp_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         push, pop;

  // -----------------------------------------------------------------------
  // Handshakes
  // -----------------------------------------------------------------------

  // Ready drops only when both words are held, so a stall loses nothing.
  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next pointers, count and storage.
  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d        = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'd1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'd1;
    end
  end

  // Register stage.
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end

endmodule // lcdc_pipe2

// file: lcdc_pkg.sv
package lcdc_pkg;

  // ---------------------------------------------------------------------
  // Clock and time conversion
  // ---------------------------------------------------------------------

  localparam int unsigned CLK_MHZ = 100;

  // Least times round up to whole cycles and never come to less than one.
  function automatic int unsigned ns2cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c == 0) ? 1 : c;
  endfunction

  // ---------------------------------------------------------------------
  // Interface times in nanoseconds
  // ---------------------------------------------------------------------

  localparam int unsigned T_SETUP_NS    = 40;
  localparam int unsigned T_STROBE_NS   = 230;
  localparam int unsigned T_HOLD_NS     = 10;
  localparam int unsigned T_NIB_GAP_NS  = 1_000;
  localparam int unsigned T_BYTE_GAP_NS = 40_000;
  localparam int unsigned T_CLEAR_NS    = 1_640_000;
  localparam int unsigned T_PWRON_NS    = 15_000_000;
  localparam int unsigned T_INIT1_NS    = 4_100_000;
  localparam int unsigned T_INIT2_NS    = 100_000;
  localparam int unsigned T_INIT3_NS    = 40_000;

  // ---------------------------------------------------------------------
  // Cycle counts derived from the times
  // ---------------------------------------------------------------------

  localparam int unsigned CYC_SETUP    = ns2cyc(T_SETUP_NS);
  localparam int unsigned CYC_STROBE   = ns2cyc(T_STROBE_NS);
  localparam int unsigned CYC_HOLD     = ns2cyc(T_HOLD_NS);
  localparam int unsigned CYC_NIB_GAP  = ns2cyc(T_NIB_GAP_NS);
  localparam int unsigned CYC_BYTE_GAP = ns2cyc(T_BYTE_GAP_NS);
  localparam int unsigned CYC_CLEAR    = ns2cyc(T_CLEAR_NS);
  localparam int unsigned CYC_PWRON    = ns2cyc(T_PWRON_NS);
  localparam int unsigned CYC_INIT1    = ns2cyc(T_INIT1_NS);
  localparam int unsigned CYC_INIT2    = ns2cyc(T_INIT2_NS);
  localparam int unsigned CYC_INIT3    = ns2cyc(T_INIT3_NS);

  // ---------------------------------------------------------------------
  // Widths, nibbles and command bytes
  // ---------------------------------------------------------------------

  localparam int unsigned CNT_W      = 24;
  localparam int unsigned WCNT_W     = 5;
  localparam int unsigned BUF_W      = 9;
  localparam int unsigned BUF_DEPTH  = 2;
  localparam int unsigned INIT_LAST  = 3;
  localparam int unsigned CFG_LAST   = 7;

  localparam logic [3:0] NIB_WAKE     = 4'h3;
  localparam logic [3:0] NIB_4BIT     = 4'h2;
  localparam logic [7:0] CMD_FUNC     = 8'h28;
  localparam logic [7:0] CMD_ENTRY    = 8'h06;
  localparam logic [7:0] CMD_DISP     = 8'h0C;
  localparam logic [7:0] CMD_CLEAR    = 8'h01;
  localparam logic [7:0] CMD_SET_ADDR = 8'h80;

  // ---------------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------------

  typedef enum logic [1:0] {
    WR_IDLE  = 2'b00,
    WR_SETUP = 2'b01,
    WR_PULSE = 2'b10,
    WR_HOLD  = 2'b11
  } lcdc_wr_e;

  typedef enum logic [1:0] {
    ST_PWRON = 2'b00,
    ST_NIB   = 2'b01,
    ST_GAP   = 2'b10,
    ST_IDLE  = 2'b11
  } lcdc_st_e;

endpackage

// file: tb_char_lcd_nibble_interface.sv
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin samples_checked++; \
  if ((got) !== (ex)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

// ----------------------------------------------------------------------
// Self-checking bench of the display controller
// ----------------------------------------------------------------------
module tb_char_lcd_nibble_interface import lcdc_pkg::*;;
  localparam int unsigned PWR = 50;
  localparam int unsigned I1  = 40;
  localparam int unsigned I2  = 30;
  localparam int unsigned CLR = 4500;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        en = 1'b0;
  logic        wr_valid = 1'b0;
  logic        wr_rs = 1'b0;
  logic [7:0]  wr_byte = 8'h00;
  logic        wr_ready, ready, rw, stb, sel, ev, ev_init, ev_rs, viol;
  logic [3:0]  nib;
  logic [7:0]  ev_byte;
  logic [9:0]  got;
  logic [31:0] seed = 32'h0000_0053;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          exp_q [$];
  int          exp_ram [128];
  int          exp_v;
  int          ptr = 0;
  bit          addr_seen = 0;

  always #5 clk = ~clk;
  assign got = {ev_init, ev_rs, ev_byte};

  lcdc_ctrl #(.P_PWRON_CYC(PWR), .P_INIT1_CYC(I1), .P_INIT2_CYC(I2),
    .P_CLEAR_CYC(CLR)) DUT (.CLK(clk), .SYS_RST(rst), .ENABLE(en),
    .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_RS(wr_rs),
    .WR_BYTE(wr_byte), .READY(ready), .NIBBLE_BUS(nib),
    .CMD_DATA_SELECT(sel), .READ_WRITE_SELECT(rw), .TRANSFER_STROBE(stb));

  lcdc_disp_model #(.P_CLEAR_CYC(CLR)) u_disp (.clk(clk),
    .transfer_strobe(stb), .nibble_bus(nib), .cmd_data_select(sel),
    .read_write_select(rw), .ev_q(ev), .ev_init_q(ev_init), .ev_rs_q(ev_rs),
    .ev_byte_q(ev_byte), .viol_q(viol));

  // Xorshift source, so a run repeats exactly.
  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  // Reference: what the display must take, and what its memory then holds.
  function automatic void expect_byte(input bit init, input bit rs,
                                      input logic [7:0] b);
    exp_q.push_back({init, rs, b});
    if (init) return;
    if (rs) begin
      exp_ram[ptr] = b;
      ptr = (ptr + 1) % 128;
    end else if (b[7]) begin
      ptr = b[6:0];
      addr_seen = 1;
    end else if (b == CMD_CLEAR) begin
      foreach (exp_ram[i]) exp_ram[i] = 'h20;
      ptr = 0;
    end else if (b[7:1] == 7'h01) begin
      ptr = 0;
    end
  endfunction

  // Offers one byte and holds it until the buffer takes it; the caller
  // lowers the valid line, so back-to-back offers never glitch it.
  task automatic put(input bit rs, input logic [7:0] b);
    int n;
    bit rdy;
    if (rs && !addr_seen) expect_byte(0, 0, CMD_SET_ADDR);
    expect_byte(0, rs, b);
    n = 0;
    rdy = 1'b0;
    wr_valid <= 1'b1;
    wr_rs <= rs;
    wr_byte <= b;
    // Ready is read mid-cycle, where it has settled for the coming edge.
    do begin
      @(negedge clk);
      rdy = wr_ready;
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 40000);
    if (n >= 40000) begin
      bad_count++;
      test_done();
    end
  endtask

  task automatic test_done();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Each byte or wake-up nibble the display takes is matched in order.
  always @(posedge clk) begin
    if (ev === 1'b1) begin
      exp_v = exp_q.size() != 0 ? exp_q.pop_front() : -1;
      `CHK("display write", exp_v, got)
    end
  end

  // Main sequence: parked start with a full buffer, then the stream.
  initial begin
    repeat (5) @(posedge clk);
    `CHK("strobe in reset", 1'b0, stb)
    `CHK("ready in reset", 1'b0, ready)
    rst <= 1'b0;
    // Wake-up nibbles first.
    for (int i = 0; i < 4; i++)
      expect_byte(1, 0, {4'h0, i == 3 ? NIB_4BIT : NIB_WAKE});
    expect_byte(0, 0, CMD_FUNC);
    expect_byte(0, 0, CMD_ENTRY);
    expect_byte(0, 0, CMD_DISP);
    expect_byte(0, 0, CMD_CLEAR);
    put(1, rnd8());
    put(1, rnd8());
    wr_valid <= 1'b0;
    #1;
    `CHK("buffer full", 1'b0, wr_ready)
    repeat (300) @(posedge clk);
    `CHK("parked nibbles", 0, u_disp.nibs_q)
    en <= 1'b1;
    put(1, rnd8());
    put(0, 8'hC3); // second line needs its own address
    put(1, rnd8());
    put(1, rnd8());
    put(0, CMD_CLEAR);
    put(0, 8'h8E);
    put(1, rnd8());
    put(0, 8'h02); // return home takes the long wait as well
    put(1, rnd8());
    wr_valid <= 1'b0;
    for (int n = 0; n < 60000 && exp_q.size() != 0; n++) @(posedge clk);
    repeat (CLR + 10) @(posedge clk);
    `CHK("pending writes", 0, exp_q.size())
    `CHK("ready", 1'b1, ready)
    `CHK("busy overrun", 1'b0, viol)
    `CHK("read/write select", 1'b0, rw)
    for (int i = 0; i < 128; i++)
      `CHK("char ram", exp_ram[i], u_disp.display_char_ram[i])
    test_done();
  end

  // Watchdog well past the expected run of about 77k cycles.
  initial begin
    #(110_000 * 10);
    bad_count++;
    test_done();
  end

endmodule // tb_char_lcd_nibble_interface
